// ---- tape_bus_partner.sv ----
/* model of the drive-side latches, status buffer and bus arbiter.
   assumes the device drives pins after posedge; it answers at negedge. */
`timescale 1ns/1ps
`default_nettype none
module tape_bus_partner #(
  parameter logic [7:0] status_byte = 8'hc6
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       slow,
  input  wire logic       ext_bus_request,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe,
  input  wire logic       port_zero_strobe,
  input  wire logic       port_one_strobe,
  input  wire logic       port_two_strobe,
  input  wire logic       port_three_strobe,
  output var  logic       ready_in,
  output var  logic [7:0] bus_in,
  output var  logic [7:0] ext_track,
  output var  logic [7:0] ext_motion,
  output var  logic [7:0] ext_latch
);
  logic [3:0] wait_cnt;
  initial ready_in = 1'b0;
  initial bus_in = 8'h00;
  // grant after a short or long wait; withdrawn when request drops
  always @(posedge ref_clk) begin
    if (sys_rst || !ext_bus_request) begin
      wait_cnt <= 4'h0;
      ready_in <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + {3'h0, wait_cnt != 4'hf};
      ready_in <= wait_cnt >= (slow ? 4'hc : 4'h1);
    end
    // latches only take data that the write strobe qualifies
    if (!write_strobe_n && bus_oe) begin
      if (port_zero_strobe) ext_latch <= bus_out;
      if (port_one_strobe) ext_track <= bus_out;
      if (port_two_strobe) ext_motion <= bus_out;
    end
  end
  // undriven bus toggles so a sample one cycle late reads the complement, though one two cycles late reads the byte again
  always @(negedge ref_clk) begin
    if (read_strobe && port_three_strobe) bus_in <= status_byte;
    else if (read_strobe && port_zero_strobe) bus_in <= ext_latch;
    else bus_in <= ~bus_in;
  end
endmodule // tape_bus_partner
`default_nettype wire

// ---- tape_ctrl_port_interface.v ----
/*
 * External port interface of the tape control processor: sequences port
 * accesses on the multiplexed 8-bit bus, drives host-bus phase lines and
 * formatter handshake lines, and synchronises all pin inputs.
 * Assumes the core logic on ref_clk issues one access at a time and the
 * pins come from outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tape_port_defines.vh"

module tape_ctrl_port_interface (
  input  wire       ref_clk,
  input  wire       sys_rst,
  // core side
  input  wire       acc_req,
  input  wire [1:0] acc_port,
  input  wire [7:0] acc_addr,
  input  wire [7:0] acc_wdata,
  output reg        acc_busy,
  output reg        acc_done,
  output reg  [7:0] acc_rdata,
  input  wire       set_cd,
  input  wire       set_io,
  input  wire       set_msg,
  input  wire       release_req,
  input  wire       xfer_on,
  input  wire       monitor_on,
  input  wire       gate_on,
  input  wire       prime_on,
  output reg  [7:0] track_head_control,
  output reg  [7:0] motion_select_control,
  output reg  [7:0] tape_drive_status,
  output reg        selftest_start,
  output wire       raw_gap_seen,
  output wire       block_done_seen,
  output wire       byte_ready_seen,
  output wire       busy_seen,
  // pins
  input  wire [7:0] bus_in,
  output reg  [7:0] bus_out,
  output reg        bus_oe,
  output reg        ale,
  output reg        write_strobe_n,
  output reg        read_strobe,
  output wire       port_zero_strobe,
  output wire       port_one_strobe,
  output wire       port_two_strobe,
  output wire       port_three_strobe,
  output reg        ext_bus_request,
  input  wire       ready_in,
  input  wire       raw_gap_in,
  input  wire       block_done_in,
  input  wire       host_byte_ready,
  input  wire       busy_in,
  output reg        host_cd,
  output reg        host_io,
  output reg        host_msg,
  output reg        bus_release_out,
  output reg        host_xfer_start,
  output reg        monitor_enable,
  output reg        read_gate,
  output reg        formatter_prime
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  reg  [12:0] sync_a_r;
  reg  [12:0] sync_b_r;
  wire [7:0]  bus_in_s;
  wire        ready_s;

  // two flops per pin; stage one feeds stage two only
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_a_r <= 13'h0000;
      sync_b_r <= 13'h0000;
    end else begin
      sync_a_r <= {bus_in, ready_in, raw_gap_in, block_done_in, host_byte_ready, busy_in};
      sync_b_r <= sync_a_r;
    end
  end

  // status byte pins are read only via the synchronised copy
  assign bus_in_s        = sync_b_r[12:5];
  assign ready_s         = sync_b_r[4];
  assign raw_gap_seen    = sync_b_r[3];
  assign block_done_seen = sync_b_r[2];
  assign byte_ready_seen = sync_b_r[1];
  assign busy_seen       = sync_b_r[0];

  // ****************************************************************
  // instruction cycle timing
  // ****************************************************************
  reg [2:0] phase_r;

  // free-running phase; wraps every instruction cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_r <= `PH_FIRST;
      ale     <= 1'b0;
    end else begin
      phase_r <= phase_r + 3'h1;
      ale     <= (phase_r == `PH_LAST);
    end
  end

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  localparam [4:0] S_IDLE = `ST_IDLE;
  localparam [4:0] S_REQ  = `ST_REQ;
  localparam [4:0] S_ADDR = `ST_ADDR;
  localparam [4:0] S_STRB = `ST_STRB;
  localparam [4:0] S_DONE = `ST_DONE;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [1:0] port_r;
  reg [7:0] addr_r;
  reg [7:0] wdata_r;
  reg       dir_wr_r;
  reg [3:0] port_strb_r;

  // address from the latch pulse phase through PH_ADDR_END, then data under the strobe
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (acc_req) begin
          state_nxt = S_REQ;
        end
      end
      S_REQ: begin
        if (ready_s && phase_r == `PH_LAST) begin
          state_nxt = S_ADDR;
        end
      end
      S_ADDR: begin
        if (phase_r == `PH_ADDR_END) begin
          state_nxt = S_STRB;
        end
      end
      S_STRB: begin
        if (phase_r == `PH_STRB_END) begin
          state_nxt = S_DONE;
        end
      end
      S_DONE: begin
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // state register and request capture; only taken when idle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r  <= S_IDLE;
      port_r   <= `PORT_LATCH;
      addr_r   <= 8'h00;
      wdata_r  <= 8'h00;
      dir_wr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == S_IDLE && acc_req) begin
        port_r  <= acc_port;
        addr_r  <= acc_addr;
        wdata_r <= acc_wdata;
        // port zero direction follows the direction line
        if (acc_port == `PORT_LATCH) begin
          dir_wr_r <= ~host_io;
        end else begin
          dir_wr_r <= (acc_port != `PORT_STATUS);
        end
      end
    end
  end

  // ****************************************************************
  // bus pins and strobes
  // ****************************************************************
  wire strobe_on;
  wire hold_bus;

  assign strobe_on = (state_nxt == S_STRB);
  assign hold_bus  = (state_nxt == S_REQ) || (state_nxt == S_ADDR) || strobe_on;

  // the bus drive and write strobe drop three clocks after ready drops mid access, through the synchroniser
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_out         <= 8'h00;
      bus_oe          <= 1'b0;
      write_strobe_n  <= 1'b1;
      read_strobe     <= 1'b0;
      ext_bus_request <= 1'b0;
    end else begin
      ext_bus_request <= hold_bus;
      bus_oe          <= ready_s && ((state_nxt == S_ADDR) || (strobe_on && dir_wr_r));
      bus_out         <= (state_nxt == S_ADDR) ? addr_r : wdata_r;
      write_strobe_n  <= ~(strobe_on && dir_wr_r && ready_s);
      read_strobe     <= strobe_on && !dir_wr_r;
    end
  end

  // one strobe per port, decoded from a single port number
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_port
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          port_strb_r[gi] <= 1'b0;
        end else begin
          port_strb_r[gi] <= strobe_on && ({30'h0, port_r} == gi);
        end
      end
    end
  endgenerate

  assign port_zero_strobe  = port_strb_r[0];
  assign port_one_strobe   = port_strb_r[1];
  assign port_two_strobe   = port_strb_r[2];
  assign port_three_strobe = port_strb_r[3];

  // ****************************************************************
  // completion, read capture and control shadows
  // ****************************************************************
  wire finish;

  assign finish = (state_r == S_STRB) && (state_nxt == S_DONE);

  // read data sampled at the last strobe phase, after the sync delay
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      acc_busy              <= 1'b0;
      acc_done              <= 1'b0;
      acc_rdata             <= 8'h00;
      track_head_control    <= `CTRL_RESET;
      motion_select_control <= `CTRL_RESET;
      tape_drive_status     <= `CTRL_RESET;
    end else begin
      acc_busy <= (state_nxt != S_IDLE);
      acc_done <= finish;
      if (finish && !dir_wr_r) begin
        acc_rdata <= bus_in_s;
        if (port_r == `PORT_STATUS) begin
          tape_drive_status <= bus_in_s;
        end
      end
      if (finish && port_r == `PORT_TRACK) begin
        track_head_control <= wdata_r;
      end
      if (finish && port_r == `PORT_MOTION) begin
        motion_select_control <= wdata_r;
      end
    end
  end

  // ****************************************************************
  // host-bus phase and formatter lines
  // ****************************************************************
  // message only qualifies as message-out: control byte, outward direction
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      host_cd         <= 1'b0;
      host_io         <= 1'b0;
      host_msg        <= 1'b0;
      bus_release_out <= 1'b0;
      host_xfer_start <= 1'b0;
      monitor_enable  <= 1'b0;
      read_gate       <= 1'b0;
      formatter_prime <= 1'b0;
    end else begin
      host_cd         <= set_cd;
      host_io         <= set_io;
      host_msg        <= set_msg && set_cd && !set_io;
      bus_release_out <= release_req;
      host_xfer_start <= xfer_on;
      monitor_enable  <= monitor_on;
      read_gate       <= gate_on;
      formatter_prime <= prime_on;
    end
  end

  // ****************************************************************
  // self-test launch
  // ****************************************************************
  reg rst_seen_r;

  // one pulse on the first edge after reset is released
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rst_seen_r     <= 1'b1;
      selftest_start <= 1'b0;
    end else begin
      rst_seen_r     <= 1'b0;
      selftest_start <= rst_seen_r;
    end
  end

endmodule // tape_ctrl_port_interface

`default_nettype wire

// ---- tape_ctrl_port_interface_test.sv ----
/* self-checking bench for the tape port interface with a drive-side partner.
   assumes 200 MHz ref_clk; inputs change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module tape_ctrl_port_interface_test;
  localparam logic [7:0] stat = 8'hc6;
  logic ref_clk = 0, sys_rst = 1, acc_req = 0, slow = 0, release_req = 0;
  logic set_cd = 0, set_io = 0, set_msg = 0, xfer_on = 0, monitor_on = 0;
  logic gate_on = 0, prime_on = 0, raw_gap_in = 0, block_done_in = 0;
  logic host_byte_ready = 0, busy_in = 0, ready_in;
  logic [1:0] acc_port = 0;
  logic [7:0] acc_addr = 0, acc_wdata = 0, acc_rdata, bus_in, bus_out;
  logic [7:0] track_head_control, motion_select_control, tape_drive_status;
  logic [7:0] ext_track, ext_motion, ext_latch;
  logic acc_busy, acc_done, selftest_start, raw_gap_seen, block_done_seen;
  logic byte_ready_seen, busy_seen, bus_oe, ale, write_strobe_n, read_strobe;
  logic port_zero_strobe, port_one_strobe, port_two_strobe, port_three_strobe;
  logic ext_bus_request, host_cd, host_io, host_msg, bus_release_out;
  logic host_xfer_start, monitor_enable, read_gate, formatter_prime;
  int n_fail = 0, num_checks = 0, i;
  // rows: port, direction, slow grant, byte
  logic [11:0] rows [5] = '{{2'h1, 1'b0, 1'b0, 8'ha5}, {2'h2, 1'b0, 1'b1, 8'h96},
    {2'h0, 1'b0, 1'b0, 8'h3c}, {2'h0, 1'b1, 1'b1, 8'h3c}, {2'h3, 1'b0, 1'b0, stat}};

  tape_ctrl_port_interface dut (.*);
  tape_bus_partner #(.status_byte(stat)) m (.*);

  // ****************************************************************
  // clock, watchdog and shared tasks
  // ****************************************************************
  initial forever #2.5 ref_clk = ~ref_clk;
  // whole run is under a thousand cycles
  initial begin
    #20000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task do_reset;
    sys_rst = 1;
    repeat (3) @(negedge ref_clk);
    chk(write_strobe_n, 1);
    sys_rst = 0;
    @(negedge ref_clk);
    chk(selftest_start, 1);
    @(negedge ref_clk);
    chk(selftest_start, 0);
    $display("reset test done");
  endtask
  // one port access, waits for completion under a bound
  task access(input logic [1:0] p, input logic [7:0] d);
    int k;
    acc_req = 1;
    acc_port = p;
    acc_addr = 8'h40 + {6'h0, p};
    acc_wdata = d;
    @(negedge ref_clk);
    acc_req = 0;
    chk(acc_busy, 1);
    chk(ext_bus_request, 1);
    for (k = 0; k < 100 && acc_done !== 1'b1; k++) @(negedge ref_clk);
    chk(acc_done, 1);
    chk(ext_bus_request, 0);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    do_reset;
    for (i = 0; i < 5; i++) begin
      set_io = rows[i][9];
      slow = rows[i][8];
      @(negedge ref_clk);
      access(rows[i][11:10], rows[i][7:0]);
      case (rows[i][11:10])
        2'h1: begin
          chk(track_head_control, rows[i][7:0]);
          chk(ext_track, rows[i][7:0]);
        end
        2'h2: begin
          chk(motion_select_control, rows[i][7:0]);
          chk(ext_motion, rows[i][7:0]);
        end
        2'h3: begin
          chk(tape_drive_status, rows[i][7:0]);
          chk(acc_rdata, rows[i][7:0]);
        end
        default: begin
          if (rows[i][9]) chk(acc_rdata, rows[i][7:0]);
          else chk(ext_latch, rows[i][7:0]);
        end
      endcase
      @(negedge ref_clk);
      chk(acc_busy, 0);
      $display("access row %0d done", i);
    end
    // phase and handshake lines follow one cycle later
    for (i = 0; i < 16; i++) begin
      {xfer_on, monitor_on, gate_on, prime_on} = i[3:0];
      {set_cd, set_io, set_msg} = i[2:0];
      release_req = i[0];
      @(negedge ref_clk);
      chk(host_xfer_start, i[3]);
      chk(monitor_enable, i[2]);
      chk(read_gate, i[1]);
      chk(formatter_prime, i[0]);
      chk(host_cd, i[2]);
      chk(host_io, i[1]);
      chk(host_msg, i[2] & ~i[1] & i[0]);
      chk(bus_release_out, i[0]);
    end
    $display("phase line test done");
    for (i = 5; i <= 10; i += 5) begin
      {raw_gap_in, block_done_in, host_byte_ready, busy_in} = i[3:0];
      repeat (2) @(negedge ref_clk);
      chk(raw_gap_seen, i[3]);
      chk(block_done_seen, i[2]);
      chk(byte_ready_seen, i[1]);
      chk(busy_seen, i[0]);
    end
    $display("input sync test done");
    do_reset;
    conclude;
  end
endmodule // tape_ctrl_port_interface_test
`default_nettype wire

// ---- tape_port_asserts.sv ----
/* checker for the tape port pins and host phase lines of the port interface.
   assumes one clock, ref_clk, and a synchronous active-high sys_rst. */
`timescale 1ns/1ps
`default_nettype none
module tape_port_asserts (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ale,
  input wire logic write_strobe_n,
  input wire logic read_strobe,
  input wire logic bus_oe,
  input wire logic port_zero_strobe,
  input wire logic port_one_strobe,
  input wire logic port_two_strobe,
  input wire logic port_three_strobe,
  input wire logic ext_bus_request,
  input wire logic set_cd,
  input wire logic set_io,
  input wire logic set_msg,
  input wire logic host_msg,
  input wire logic release_req,
  input wire logic bus_release_out,
  input wire logic xfer_on,
  input wire logic host_xfer_start
);
  // ****************************************************************
  // shared clocking
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // any port strobe, so one latch at a time is visible
  wire [3:0] strb = {port_three_strobe, port_two_strobe, port_one_strobe, port_zero_strobe};

  a_one_strobe: assert property ($onehot0(strb))
    else $error("two port strobes at once");
  a_write_drives: assert property (!write_strobe_n |-> bus_oe && ext_bus_request)
    else $error("write strobe without driven bus");
  a_read_floats: assert property (read_strobe |-> !bus_oe)
    else $error("bus driven while reading");
  a_drive_granted: assert property (bus_oe |-> ext_bus_request)
    else $error("bus driven without request");
  a_addr_first: assert property ($rose(|strb) |-> $past(ale, 3))
    else $error("strobe not preceded by address phase");
  a_ale_period: assert property (ale |=> !ale [*7] ##1 ale)
    else $error("address latch not once per cycle");
  a_msg_phase: assert property (host_msg |-> $past(set_msg && set_cd && !set_io))
    else $error("message outside message-out phase");
  a_release_pulse: assert property (release_req |=> bus_release_out)
    else $error("bus release not signalled");
  a_xfer_follow: assert property (xfer_on |=> host_xfer_start)
    else $error("start transfer not asserted");
endmodule // tape_port_asserts

bind tape_ctrl_port_interface tape_port_asserts chk (.*);
`default_nettype wire

// ---- tape_port_defines.vh ----
/*
 * Constants of the tape control processor's external port interface:
 * access timing, state codes, port numbers, control and status field positions.
 * Assumes one clock, ref_clk at 200 MHz, and a synchronous active-high reset.
 */
`ifndef TAPE_PORT_DEFINES_VH
`define TAPE_PORT_DEFINES_VH

// ****************************************************************
// instruction cycle phases (8 clocks per instruction cycle)
// ****************************************************************
`define PH_FIRST     3'h0
`define PH_ADDR_END  3'h2
`define PH_STRB_END  3'h6
`define PH_LAST      3'h7

// ****************************************************************
// access sequencer states, one-hot
// ****************************************************************
`define ST_IDLE      5'h01
`define ST_REQ       5'h02
`define ST_ADDR      5'h04
`define ST_STRB      5'h08
`define ST_DONE      5'h10

// ****************************************************************
// port numbers and reset values
// ****************************************************************
`define PORT_LATCH   2'h0
`define PORT_TRACK   2'h1
`define PORT_MOTION  2'h2
`define PORT_STATUS  2'h3
`define CTRL_RESET   8'h00

// ****************************************************************
// field positions of the control and status bytes
// ****************************************************************
`define TRK_LSB      0
`define TRK_MSB      3
`define TRK_HEAD_CUR 4
`define TRK_SPY_PRM  5
`define MOT_WRITE    0
`define MOT_ERASE    1
`define MOT_REVERSE  2
`define MOT_START    3
`define MOT_SELECT   4
`define MOT_THRESH   5
`define MOT_HOST_EN  7
`define STS_UP_HOLE  0
`define STS_LO_HOLE  1
`define STS_SELECTED 2
`define STS_CART_IN  3
`define STS_WR_EN    4
`define STS_TACHO    5
`define STS_ABORT    6
`define STS_NO_DATA  7

`endif
